// >>> src/ocsrt_pkg.sv
/*
  Shared constants and types of the overcurrent stage block: register map, field positions,
  values after reset, forced-state codes and the stage state encoding.
  Assumes a 5 ms measurement refresh strobe and magnitudes and thresholds in units of 0.01 x In.
*/
package ocsrt_pkg;

  localparam int unsigned NUM_STAGES = 4;
  localparam int unsigned MAG_W      = 16;

  // Timer base: every counter advances once per measurement refresh.
  localparam int unsigned TICK_MS        = 5;
  localparam int unsigned RELEASE_RST_MS = 60;
  localparam logic [15:0] RELEASE_RST    = 16'(RELEASE_RST_MS / TICK_MS);
  localparam logic [15:0] OPDELAY_RST    = 16'h0014;
  localparam logic [15:0] THRESHOLD_RST  = 16'h0078;

  // Pick-up drops out below 97 percent of the threshold.
  localparam logic [7:0] DROP_NUM = 8'h61;
  localparam logic [7:0] DROP_DEN = 8'h64;

  // Byte addresses: each stage owns a block of four words.
  localparam logic [7:0] STAGE_STRIDE = 8'h10;
  localparam logic [3:0] OFS_CTRL     = 4'h0;
  localparam logic [3:0] OFS_THRESH   = 4'h4;
  localparam logic [3:0] OFS_RELEASE  = 4'h8;
  localparam logic [3:0] OFS_OPDELAY  = 4'hc;
  localparam logic [7:0] ADDR_FORCE   = 8'h40;
  localparam logic [7:0] ADDR_STATUS  = 8'h44;

  // Stage control word fields.
  localparam int unsigned CTRL_DLY_REL  = 0;
  localparam int unsigned CTRL_OP_RST   = 1;
  localparam int unsigned CTRL_CONT     = 2;
  localparam int unsigned CTRL_MSEL_LO  = 3;
  localparam int unsigned CTRL_BUS_OK   = 5;
  localparam int unsigned CTRL_FORCE_LO = 8;
  localparam logic [31:0] CTRL_RST      = 32'h0000_0003;
  localparam logic [31:0] CTRL_MASK     = 32'h0000_1f3f;

  typedef enum logic [1:0] {
    OCSRT_MAG_RMS  = 2'h0,
    OCSRT_MAG_TRMS = 2'h1,
    OCSRT_MAG_PP   = 2'h2
  } ocsrt_msel_t;

  // Forced-state codes; 0 is normal operation.
  localparam logic [4:0] FRC_NORMAL  = 5'h00;
  localparam logic [4:0] FRC_START   = 5'h01;
  localparam logic [4:0] FRC_TRIP    = 5'h02;
  localparam logic [4:0] FRC_BLOCKED = 5'h03;
  localparam logic [4:0] FRC_ST_A    = 5'h04;
  localparam logic [4:0] FRC_TR_A    = 5'h07;
  localparam logic [4:0] FRC_ST_AB   = 5'h0a;
  localparam logic [4:0] FRC_ST_ABC  = 5'h0d;
  localparam logic [4:0] FRC_TR_AB   = 5'h0e;
  localparam logic [4:0] FRC_TR_ABC  = 5'h11;

  typedef enum logic [4:0] {
    OCSRT_IDLE    = 5'b00001,
    OCSRT_RUN     = 5'b00010,
    OCSRT_RELEASE = 5'b00100,
    OCSRT_TRIPPED = 5'b01000,
    OCSRT_BLOCKED = 5'b10000
  } ocsrt_state_t;

endpackage

// >>> src/ocsrt_stage.sv
/*
  One overcurrent stage: per-phase pick-up with hysteresis, start hold, release and operating timers.
  Assumes tick_in is a one-cycle strobe at each 5 ms measurement refresh and settings are static
  between ticks.
*/
`timescale 1ns/1ps
module ocsrt_stage (
  input  wire logic        clk_sys_in,          // System clock.
  input  wire logic        rst_in,              // Synchronous reset, active high.
  input  wire logic        tick_in,             // Measurement refresh strobe.
  input  wire logic [15:0] mag_a_in,            // Selected phase A magnitude.
  input  wire logic [15:0] mag_b_in,            // Selected phase B magnitude.
  input  wire logic [15:0] mag_c_in,            // Selected phase C magnitude.
  input  wire logic [15:0] threshold_in,        // Pick-up threshold.
  input  wire logic        block_in,            // Block input.
  input  wire logic        delayed_release_in,  // Hold start through release delay.
  input  wire logic        op_reset_after_in,   // Clear operating counter only after release delay.
  input  wire logic        continue_in,         // Keep operating counter running in release.
  input  wire logic [15:0] release_ticks_in,    // Release delay in ticks.
  input  wire logic [15:0] op_ticks_in,         // Signed operating delay in ticks.
  output logic             start_out,           // Start state.
  output logic             trip_out,            // Trip state.
  output logic             blocked_out,         // Blocked state.
  output logic [2:0]       phase_pickup_out     // Per-phase pick-up.
);

  ocsrt_pkg::ocsrt_state_t state_q, state_d;
  logic [2:0]  pu_q;
  logic [15:0] op_cnt_q, op_cnt_d;
  logic [15:0] rel_cnt_q, rel_cnt_d;

  function automatic logic above(input logic [15:0] mag, input logic [15:0] thr);
    above = mag > thr;
  endfunction

  function automatic logic below_drop(input logic [15:0] mag, input logic [15:0] thr);
    below_drop = (24'(mag) * 24'(ocsrt_pkg::DROP_DEN)) < (24'(thr) * 24'(ocsrt_pkg::DROP_NUM));
  endfunction

  wire [15:0] mags [3] = '{mag_a_in, mag_b_in, mag_c_in};
  wire [2:0] pu_new;
  for (genvar i = 0; i < 3; i++) begin : g_ph
    assign pu_new[i] = above(mags[i], threshold_in) | (pu_q[i] & ~below_drop(mags[i], threshold_in));
  end
  wire any_pu = |pu_new;
  wire op_zero = op_ticks_in[15] | (op_ticks_in == 16'h0000);
  wire op_done = op_zero | ({1'b0, op_cnt_q} + 17'h00001 >= {1'b0, op_ticks_in});
  wire rel_done = ({1'b0, rel_cnt_q} + 17'h00001 >= {1'b0, release_ticks_in});
  wire [15:0] op_inc = (op_cnt_q == 16'hffff) ? op_cnt_q : op_cnt_q + 16'h0001;

  always_comb begin
    state_d = state_q;
    op_cnt_d = op_cnt_q;
    rel_cnt_d = rel_cnt_q;
    if (tick_in) begin
      unique case (state_q)
        ocsrt_pkg::OCSRT_IDLE: begin
          op_cnt_d = 16'h0000;
          if (any_pu) begin
            state_d = block_in ? ocsrt_pkg::OCSRT_BLOCKED : ocsrt_pkg::OCSRT_RUN;
          end
        end
        ocsrt_pkg::OCSRT_RUN: begin
          if (any_pu && !block_in) begin
            op_cnt_d = op_inc;
            if (op_done) begin
              state_d = ocsrt_pkg::OCSRT_TRIPPED;
            end
          end else begin
            // A block after start is handled like a pick-up drop.
            state_d = ocsrt_pkg::OCSRT_RELEASE;
            rel_cnt_d = 16'h0000;
            if (!op_reset_after_in) begin
              op_cnt_d = 16'h0000;
            end
          end
        end
        ocsrt_pkg::OCSRT_RELEASE: begin
          if (any_pu && !block_in) begin
            state_d = ocsrt_pkg::OCSRT_RUN;
          end else begin
            rel_cnt_d = rel_cnt_q + 16'h0001;
            if (continue_in) begin
              op_cnt_d = op_inc;
            end
            if (rel_done) begin
              state_d = ocsrt_pkg::OCSRT_IDLE;
              op_cnt_d = 16'h0000;
            end
          end
        end
        ocsrt_pkg::OCSRT_TRIPPED: begin
          if (!any_pu) begin
            state_d = ocsrt_pkg::OCSRT_IDLE;
          end
        end
        ocsrt_pkg::OCSRT_BLOCKED: begin
          if (!any_pu) begin
            state_d = ocsrt_pkg::OCSRT_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_q <= ocsrt_pkg::OCSRT_IDLE;
      pu_q <= 3'h0;
      op_cnt_q <= 16'h0000;
      rel_cnt_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      pu_q <= tick_in ? pu_new : pu_q;
      op_cnt_q <= op_cnt_d;
      rel_cnt_q <= rel_cnt_d;
    end
  end

  // Start is held through release only when delayed release is chosen.
  assign start_out = (state_q == ocsrt_pkg::OCSRT_RUN) || (state_q == ocsrt_pkg::OCSRT_TRIPPED) ||
                     ((state_q == ocsrt_pkg::OCSRT_RELEASE) && delayed_release_in);
  assign trip_out = state_q == ocsrt_pkg::OCSRT_TRIPPED;
  assign blocked_out = state_q == ocsrt_pkg::OCSRT_BLOCKED;
  assign phase_pickup_out = pu_q;

endmodule

// >>> src/ocsrt_top.sv
/*
  Four-stage phase overcurrent block with an Avalon-MM register slave, a local setting port,
  magnitude selection and forced-state test control.
  Assumes all inputs are synchronous to clk_sys_in and meas_tick_in pulses once per 5 ms refresh.
*/
// Our own choices: the register offsets and the Avalon-MM slave port.
//
// Overview of operation
// - Negative or zero operating delay trips on the first refresh after start.
// - Counting during release never trips unless pick-up returns first.
// - Delayed release holds start through release delay; otherwise start clears immediately.
// - Release delay in 5 ms steps, default 60 ms, bridges gaps between pick-ups.
// - Default: operating counter held, cleared only when release delay expires.
// - Without reset-after-release, operating counter clears when pick-up drops.
// - Continue option keeps the operating counter advancing during release.
// - Global forcing enable lets software set any stage state directly.
// - While forcing, measured currents still drive the stage as well.
// - Four independent stages with own settings, timers and outputs.
// - Magnitude select: fundamental RMS (default), true RMS or peak-to-peak.
// - All nine phase magnitude words are inputs refreshed every 5 ms.
// - General settings are static and unaffected by setting group changes.
// - Bus writes to the threshold take effect only when bus setting is allowed.
// - Forced-status selector acts only with forcing enabled; default normal.
// - Decisions use phase magnitude; one, two or three phases can operate.
// - Pick-up above threshold, drop-out only below 97 percent of it.
// - Block input active at pick-up gives blocked instead of start, no timing.
`timescale 1ns/1ps
module ocsrt_top (
  input  wire logic        clk_sys_in,          // 200 MHz system clock.
  input  wire logic        rst_in,              // Synchronous reset, active high.
  input  wire logic [7:0]  avs_address,         // Byte address.
  input  wire logic        avs_read,            // Read request.
  input  wire logic        avs_write,           // Write request.
  input  wire logic [31:0] avs_writedata,       // Write data.
  input  wire logic [3:0]  avs_byteenable,      // Byte enables.
  output logic [31:0]      avs_readdata,        // Read data.
  output logic             avs_waitrequest,     // Wait request.
  input  wire logic        local_set_valid_in,  // Local threshold write strobe.
  input  wire logic [1:0]  local_set_stage_in,  // Local write target stage.
  input  wire logic [15:0] local_set_value_in,  // Local threshold value.
  input  wire logic        meas_tick_in,        // 5 ms refresh strobe.
  input  wire logic [15:0] phase_a_current_rms_in,   // Phase A fundamental RMS.
  input  wire logic [15:0] phase_b_current_rms_in,   // Phase B fundamental RMS.
  input  wire logic [15:0] phase_c_current_rms_in,   // Phase C fundamental RMS.
  input  wire logic [15:0] phase_a_current_trms_in,  // Phase A true RMS.
  input  wire logic [15:0] phase_b_current_trms_in,  // Phase B true RMS.
  input  wire logic [15:0] phase_c_current_trms_in,  // Phase C true RMS.
  input  wire logic [15:0] phase_a_current_pp_in,    // Phase A peak-to-peak.
  input  wire logic [15:0] phase_b_current_pp_in,    // Phase B peak-to-peak.
  input  wire logic [15:0] phase_c_current_pp_in,    // Phase C peak-to-peak.
  input  wire logic [3:0]  block_in,            // Per-stage block inputs.
  output logic [3:0]       start_out,           // Per-stage start.
  output logic [3:0]       trip_out,            // Per-stage trip.
  output logic [3:0]       blocked_out,         // Per-stage blocked.
  output logic [11:0]      phase_start_out,     // Per-stage phase start, 3 bits each.
  output logic [11:0]      phase_trip_out       // Per-stage phase trip, 3 bits each.
);

  localparam int unsigned NS = ocsrt_pkg::NUM_STAGES;

  logic [31:0] ctrl_q      [NS];
  logic [15:0] thresh_q    [NS];
  logic [15:0] release_q   [NS];
  logic [15:0] opdelay_q   [NS];
  logic        force_en_q;
  logic        wait_q;
  logic [31:0] rdata_q;
  logic [3:0]  start_q, trip_q, blocked_q;
  logic [11:0] ph_start_q, ph_trip_q;

  // Forced-state decode: {blocked, trip[2:0], start[2:0]}.
  function automatic logic [6:0] force_decode(input logic [4:0] sel);
    logic [6:0] r;
    r = 7'h00;
    if (sel == ocsrt_pkg::FRC_START) begin
      r = 7'h07;
    end else if (sel == ocsrt_pkg::FRC_TRIP) begin
      r = 7'h3f;
    end else if (sel == ocsrt_pkg::FRC_BLOCKED) begin
      r = 7'h40;
    end else if (sel >= ocsrt_pkg::FRC_ST_A && sel < ocsrt_pkg::FRC_TR_A) begin
      r = {4'h0, 3'(3'h1 << (sel - ocsrt_pkg::FRC_ST_A))};
    end else if (sel >= ocsrt_pkg::FRC_TR_A && sel < ocsrt_pkg::FRC_ST_AB) begin
      r = {1'b0, 3'(3'h1 << (sel - ocsrt_pkg::FRC_TR_A)), 3'(3'h1 << (sel - ocsrt_pkg::FRC_TR_A))};
    end else if (sel >= ocsrt_pkg::FRC_ST_AB && sel < ocsrt_pkg::FRC_ST_ABC) begin
      r = {4'h0, pair_mask(5'(sel - ocsrt_pkg::FRC_ST_AB))};
    end else if (sel == ocsrt_pkg::FRC_ST_ABC) begin
      r = 7'h07;
    end else if (sel >= ocsrt_pkg::FRC_TR_AB && sel < ocsrt_pkg::FRC_TR_ABC) begin
      r = {1'b0, pair_mask(5'(sel - ocsrt_pkg::FRC_TR_AB)), pair_mask(5'(sel - ocsrt_pkg::FRC_TR_AB))};
    end else if (sel == ocsrt_pkg::FRC_TR_ABC) begin
      r = 7'h3f;
    end
    return r;
  endfunction

  // Two-phase masks in the order AB, BC, CA.
  function automatic logic [2:0] pair_mask(input logic [4:0] idx);
    logic [2:0] m;
    m = 3'h5;
    if (idx == 5'h00) begin
      m = 3'h3;
    end else if (idx == 5'h01) begin
      m = 3'h6;
    end
    return m;
  endfunction

  function automatic logic [15:0] mag_select(input logic [1:0] sel, input logic [15:0] rms,
                                             input logic [15:0] trms, input logic [15:0] pp);
    logic [15:0] m;
    m = rms;
    if (sel == ocsrt_pkg::OCSRT_MAG_TRMS) begin
      m = trms;
    end else if (sel == ocsrt_pkg::OCSRT_MAG_PP) begin
      m = pp;
    end
    return m;
  endfunction

  function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Bus decode: the answer comes one cycle after the request is first seen.
  wire        bus_req    = avs_read | avs_write;
  wire        bus_accept = bus_req & ~wait_q;
  wire        wr_fire    = avs_write & bus_accept;
  wire [1:0]  sel_stage  = avs_address[5:4];
  wire [3:0]  sel_ofs    = avs_address[3:0];
  wire        in_stage   = avs_address < ocsrt_pkg::ADDR_FORCE;
  wire        hit_force  = avs_address == ocsrt_pkg::ADDR_FORCE;
  wire        hit_status = avs_address == ocsrt_pkg::ADDR_STATUS;

  wire [31:0] ctrl_rd = ctrl_q[sel_stage];
  wire [31:0] stage_rd = (sel_ofs == ocsrt_pkg::OFS_CTRL)    ? ctrl_rd :
                         (sel_ofs == ocsrt_pkg::OFS_THRESH)  ? {16'h0000, thresh_q[sel_stage]} :
                         (sel_ofs == ocsrt_pkg::OFS_RELEASE) ? {16'h0000, release_q[sel_stage]} :
                         (sel_ofs == ocsrt_pkg::OFS_OPDELAY) ? {16'h0000, opdelay_q[sel_stage]} : 32'h0000_0000;
  wire [31:0] status_rd = {8'h00, ph_trip_q[7:0], 4'h0, blocked_q, trip_q, start_q};
  wire [31:0] rd_mux = in_stage   ? stage_rd :
                       hit_force  ? {31'h0000_0000, force_en_q} :
                       hit_status ? status_rd : 32'h0000_0000;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q <= ~(bus_req & wait_q);
      rdata_q <= (avs_read & wait_q) ? rd_mux : rdata_q;
    end
  end
  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;

  // Stage settings; general control words are never touched by any group switch.
  for (genvar s = 0; s < NS; s++) begin : g_set
    wire hit = wr_fire & in_stage & (sel_stage == 2'(s));
    wire bus_ok = ctrl_q[s][ocsrt_pkg::CTRL_BUS_OK];
    wire loc_hit = local_set_valid_in & (local_set_stage_in == 2'(s));
    wire thr_bus = hit & (sel_ofs == ocsrt_pkg::OFS_THRESH) & bus_ok;
    wire [31:0] thr_merge = merge_be({16'h0000, thresh_q[s]}, avs_writedata, avs_byteenable);
    always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
        ctrl_q[s] <= ocsrt_pkg::CTRL_RST;
        thresh_q[s] <= ocsrt_pkg::THRESHOLD_RST;
        release_q[s] <= ocsrt_pkg::RELEASE_RST;
        opdelay_q[s] <= ocsrt_pkg::OPDELAY_RST;
      end else begin
        if (hit && sel_ofs == ocsrt_pkg::OFS_CTRL) begin
          ctrl_q[s] <= merge_be(ctrl_q[s], avs_writedata, avs_byteenable) & ocsrt_pkg::CTRL_MASK;
        end
        if (loc_hit) begin
          thresh_q[s] <= local_set_value_in;
        end else if (thr_bus) begin
          thresh_q[s] <= thr_merge[15:0];
        end
        if (hit && sel_ofs == ocsrt_pkg::OFS_RELEASE) begin
          release_q[s] <= 16'(merge_be({16'h0000, release_q[s]}, avs_writedata, avs_byteenable));
        end
        if (hit && sel_ofs == ocsrt_pkg::OFS_OPDELAY) begin
          opdelay_q[s] <= 16'(merge_be({16'h0000, opdelay_q[s]}, avs_writedata, avs_byteenable));
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      force_en_q <= 1'b0;
    end else if (wr_fire && hit_force && avs_byteenable[0]) begin
      force_en_q <= avs_writedata[0];
    end
  end

  // Stage instances and output merge.
  for (genvar s = 0; s < NS; s++) begin : g_stage
    wire [1:0] msel = ctrl_q[s][ocsrt_pkg::CTRL_MSEL_LO +: 2];
    wire [15:0] mag_a = mag_select(msel, phase_a_current_rms_in, phase_a_current_trms_in,
                                   phase_a_current_pp_in);
    wire [15:0] mag_b = mag_select(msel, phase_b_current_rms_in, phase_b_current_trms_in, phase_b_current_pp_in);
    wire [15:0] mag_c = mag_select(msel, phase_c_current_rms_in, phase_c_current_trms_in, phase_c_current_pp_in);
    wire st, tr, bl;
    wire [2:0] ph;
    // Forcing overlays the measured behaviour; it never suppresses it.
    wire [6:0] frc = force_en_q ? force_decode(ctrl_q[s][ocsrt_pkg::CTRL_FORCE_LO +: 5]) : 7'h00;

    ocsrt_stage u_stage (
      .clk_sys_in         (clk_sys_in),
      .rst_in             (rst_in),
      .tick_in            (meas_tick_in),
      .mag_a_in           (mag_a),
      .mag_b_in           (mag_b),
      .mag_c_in           (mag_c),
      .threshold_in       (thresh_q[s]),
      .block_in           (block_in[s]),
      .delayed_release_in (ctrl_q[s][ocsrt_pkg::CTRL_DLY_REL]),
      .op_reset_after_in  (ctrl_q[s][ocsrt_pkg::CTRL_OP_RST]),
      .continue_in        (ctrl_q[s][ocsrt_pkg::CTRL_CONT]),
      .release_ticks_in   (release_q[s]),
      .op_ticks_in        (opdelay_q[s]),
      .start_out          (st),
      .trip_out           (tr),
      .blocked_out        (bl),
      .phase_pickup_out   (ph)
    );

    always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
        start_q[s] <= 1'b0;
        trip_q[s] <= 1'b0;
        blocked_q[s] <= 1'b0;
        ph_start_q[3*s +: 3] <= 3'h0;
        ph_trip_q[3*s +: 3] <= 3'h0;
      end else begin
        start_q[s] <= st | (|frc[2:0]);
        trip_q[s] <= tr | (|frc[5:3]);
        blocked_q[s] <= bl | frc[6];
        ph_start_q[3*s +: 3] <= (st ? ph : 3'h0) | frc[2:0];
        ph_trip_q[3*s +: 3] <= (tr ? ph : 3'h0) | frc[5:3];
      end
    end
  end

  assign start_out = start_q;
  assign trip_out = trip_q;
  assign blocked_out = blocked_q;
  assign phase_start_out = ph_start_q;
  assign phase_trip_out = ph_trip_q;

endmodule

// >>> verification/ocsrt_asserts.sv
/*
  Port checks for the four-stage overcurrent block: register bus handshake and stage outputs.
  Assumes it is bound to ocsrt_top, one clock, synchronous active-high reset.
*/
`timescale 1ns/1ps
module ocsrt_asserts (
  input  wire logic        clk_sys_in,       // System clock.
  input  wire logic        rst_in,           // Synchronous reset.
  input  wire logic        avs_read,         // Read request.
  input  wire logic        avs_write,        // Write request.
  input  wire logic        avs_waitrequest,  // Wait request.
  input  wire logic [31:0] avs_readdata,     // Read data.
  input  wire logic        meas_tick_in,     // Refresh strobe.
  input  wire logic [3:0]  start_out,        // Stage start.
  input  wire logic [3:0]  trip_out,         // Stage trip.
  input  wire logic [3:0]  blocked_out,      // Stage blocked.
  input  wire logic [11:0] phase_start_out,  // Phase start.
  input  wire logic [11:0] phase_trip_out    // Phase trip.
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // Stage outputs may only move after a refresh or an accepted write, never on their own.
  wire logic       ev_w  = meas_tick_in | (avs_write & ~avs_waitrequest);
  wire logic [3:0] pst_w = {|phase_start_out[11:9], |phase_start_out[8:6], |phase_start_out[5:3], |phase_start_out[2:0]};
  wire logic [3:0] ptr_w = {|phase_trip_out[11:9], |phase_trip_out[8:6], |phase_trip_out[5:3], |phase_trip_out[2:0]};
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered in one cycle");
  wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low too long");
  wait_cause_a: assert property (!avs_waitrequest |-> $past(avs_read || avs_write)) else $error("answer without request");
  rdata_hold_a: assert property ($changed(avs_readdata) |-> avs_read && !avs_waitrequest)
    else $error("read data moved outside a read answer");
  reset_clear_a: assert property ($fell(rst_in) |-> {start_out, trip_out, blocked_out} == 12'h000 && avs_waitrequest)
    else $error("outputs not cleared by reset");
  out_cause_a: assert property ($changed({start_out, trip_out, blocked_out}) |-> $past(ev_w) || $past(ev_w, 2) || $past(ev_w, 3))
    else $error("stage output changed without tick or write");
  ptrip_sub_a: assert property ((ptr_w & ~trip_out) == 4'h0) else $error("phase trip without stage trip");
  pstart_sub_a: assert property ((pst_w & ~start_out) == 4'h0) else $error("phase start without stage start");
  trip_seen_c: cover property (|trip_out);
  block_seen_c: cover property (|blocked_out);
  write_seen_c: cover property (avs_write && !avs_waitrequest);
endmodule

bind ocsrt_top ocsrt_asserts u_chk (.clk_sys_in, .rst_in, .avs_read, .avs_write, .avs_waitrequest, .avs_readdata,
  .meas_tick_in, .start_out, .trip_out, .blocked_out, .phase_start_out, .phase_trip_out);

// >>> verification/ocsrt_meas_model.sv
/*
  Measurement front end: refresh strobe every 8 cycles and three magnitude forms of three phases.
  Assumes the bench sets the wanted magnitudes and the form that should carry them.
*/
`timescale 1ns/1ps
module ocsrt_meas_model (
  input  wire logic        clk_sys_in,  // System clock.
  input  wire logic        rst_in,      // Synchronous reset.
  input  wire logic [1:0]  form_in,     // Form carrying the true values.
  input  wire logic [47:0] mag_in,      // Phases C, B, A.
  output logic             tick_out,    // Refresh strobe.
  output logic [47:0]      rms_out,     // Fundamental values.
  output logic [47:0]      trms_out,    // True RMS values.
  output logic [47:0]      pp_out       // Peak-to-peak values.
);
  logic [2:0] cnt_q;
  // Unused forms carry the inverse, so a wrong selection shows up as a wrong pick-up.
  always_ff @(posedge clk_sys_in) begin
    cnt_q    <= rst_in ? 3'h0 : cnt_q + 3'h1;
    tick_out <= !rst_in && cnt_q == 3'h7;
    if (rst_in) begin
      {rms_out, trms_out, pp_out} <= '0;
    end else if (cnt_q == 3'h7) begin
      rms_out  <= form_in == 2'h0 ? mag_in : ~mag_in;
      trms_out <= form_in == 2'h1 ? mag_in : ~mag_in;
      pp_out   <= form_in == 2'h2 ? mag_in : ~mag_in;
    end
  end
endmodule

// >>> verification/ocsrt_top_test.sv
/*
  Self-checking bench for the four-stage overcurrent block.
  Assumes the measurement model refreshes every 8 cycles and the bus answers by waitrequest.
*/
`timescale 1ns/1ps
module ocsrt_top_test;
  logic        clk_sys_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd_q;
  logic        avs_waitrequest, tick;
  logic        lvalid = 1'b0;
  logic [1:0]  lstage = 2'h0, form = 2'h0, p;
  logic [15:0] lvalue = 16'h0;
  logic [47:0] mag = 48'h0, rms, trms, pp;
  logic [3:0]  blk = 4'h0, start_out, trip_out, blocked_out;
  logic [11:0] phase_start_out, phase_trip_out;
  int          fail_count = 0, n_compared = 0, cyc = 0;

  always #2.5 clk_sys_in = ~clk_sys_in;

  ocsrt_meas_model meas_u (.clk_sys_in, .rst_in, .form_in(form), .mag_in(mag), .tick_out(tick),
    .rms_out(rms), .trms_out(trms), .pp_out(pp));
  ocsrt_top dut_u (.clk_sys_in, .rst_in, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .local_set_valid_in(lvalid),
    .local_set_stage_in(lstage), .local_set_value_in(lvalue), .meas_tick_in(tick),
    .phase_a_current_rms_in(rms[15:0]), .phase_b_current_rms_in(rms[31:16]), .phase_c_current_rms_in(rms[47:32]),
    .phase_a_current_trms_in(trms[15:0]), .phase_b_current_trms_in(trms[31:16]), .phase_c_current_trms_in(trms[47:32]),
    .phase_a_current_pp_in(pp[15:0]), .phase_b_current_pp_in(pp[31:16]), .phase_c_current_pp_in(pp[47:32]),
    .block_in(blk), .start_out, .trip_out, .blocked_out, .phase_start_out, .phase_trip_out);

  function automatic logic [2:0] above(input logic [47:0] m, input logic [15:0] t);
    return {m[47:32] > t, m[31:16] > t, m[15:0] > t};
  endfunction

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    avs_write     <= w;
    avs_read      <= !w;
    avs_address   <= a;
    avs_writedata <= d;
    do @(posedge clk_sys_in); while (avs_waitrequest !== 1'b0);
    rd_q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, e, rd_q);
  endtask

  task automatic wt(input int n);
    repeat (8 * n + 3) @(posedge clk_sys_in);
  endtask

  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      report_and_stop();
    end
  end

  initial begin
    void'($urandom(32'ha73353aa));
    repeat (20) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      rdchk("ctrl", 8'(16 * s), ocsrt_pkg::CTRL_RST);
      rdchk("thresh", 8'(16 * s + 4), 32'(ocsrt_pkg::THRESHOLD_RST));
      rdchk("release", 8'(16 * s + 8), 32'h0000_000c);
    end
    bus(1'b1, 8'h48, 32'hffff_ffff);
    rdchk("unmapped", 8'h48, 32'h0);
    rdchk("force_en", ocsrt_pkg::ADDR_FORCE, 32'h0);
    bus(1'b1, 8'h04, 32'h0000_0050);
    rdchk("thr_locked", 8'h04, 32'h0000_0078);
    bus(1'b1, 8'h00, 32'h0000_0023);
    bus(1'b1, 8'h04, 32'h0000_0050);
    rdchk("thr_bus", 8'h04, 32'h0000_0050);
    bus(1'b1, 8'h04, 32'h0000_0078);
    lvalid <= 1'b1;
    lstage <= 2'h3;
    lvalue <= 16'h0096;
    @(posedge clk_sys_in);
    lvalid <= 1'b0;
    rdchk("thr_local", 8'h34, 32'h0000_0096);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      p = 2'($urandom % 3);
      bus(1'b1, 8'h00, 32'((i % 3) * 8 + (i < 3 ? 3 : 2)));
      form <= 2'(i % 3);
      mag  <= 48'(16'd121 + 16'($urandom % 200)) << (16 * p);
      wt(2);
      chk("start", 32'h1, start_out[0]);
      chk("phases", above(mag, 16'd120), phase_start_out[2:0]);
      mag <= 48'(16'd117) << (16 * p);
      wt(2);
      chk("hysteresis", 32'h1, start_out[0]);
      mag <= 48'(16'd116) << (16 * p);
      wt(2);
      chk("hold", 32'(i < 3), start_out[0]);
      wt(12);
      chk("released", 32'h0, start_out[0]);
    end
    $display("test pickup and release done");
    mag  <= 48'h0;
    form <= 2'h0;
    wt(14);
    bus(1'b1, 8'h1c, 32'h0);
    bus(1'b1, 8'h3c, 32'h0000_fff0);
    blk <= 4'b0100;
    mag <= {3{16'd200}};
    wt(3);
    chk("trip", 32'h0000_000a, trip_out);
    chk("blocked", 32'h0000_0004, blocked_out);
    chk("phase_trip", 32'h0000_0007, phase_trip_out[5:3]);
    mag <= 48'h0;
    blk <= 4'h0;
    wt(14);
    $display("test trip and block done");
    bus(1'b1, 8'h00, 32'({ocsrt_pkg::FRC_TRIP, 8'h03}));
    wt(1);
    chk("force_off", 32'h0, trip_out[0]);
    bus(1'b1, ocsrt_pkg::ADDR_FORCE, 32'h1);
    wt(1);
    chk("force_on", 32'h1, trip_out[0]);
    bus(1'b0, ocsrt_pkg::ADDR_STATUS, 32'h0);
    chk("status", 32'h0000_0011, rd_q & 32'h0000_0011);
    bus(1'b1, ocsrt_pkg::ADDR_FORCE, 32'h0);
    wt(1);
    chk("force_clear", 32'h0, trip_out[0]);
    $display("test forcing done");
    report_and_stop();
  end
endmodule
